// *** rtl/mrom_pkg.sv ***
// Constants shared by the masked read-only array controller and its leaves.
// Assumes a 200 MHz system clock and a 24-bit intermodule bus address.
package mrom_pkg;
   localparam int ADDR_W     = 24;
   localparam int REG_OFF_W  = 5;
   localparam int REG_DATA_W = 16;
   localparam int MEM_DATA_W = 32;
   localparam int ROM_IDX_W  = 12;
   localparam int CNT_W      = 4;

   // Array is 8 Kbyte of 16-bit words; register block is 32 bytes
   localparam int ROM_BLOCK_LSB = 13;
   localparam int REG_BLOCK_LSB = 5;
   localparam logic [23:0] REG_BLOCK_BASE = 24'hFFF820;

   // Register offsets, byte addresses inside the block
   localparam logic [4:0] OFF_CONFIG  = 5'h00;
   localparam logic [4:0] OFF_BASE_HI = 5'h04;
   localparam logic [4:0] OFF_BASE_LO = 5'h06;
   localparam logic [4:0] OFF_SIG_HI  = 5'h08;
   localparam logic [4:0] OFF_SIG_LO  = 5'h0A;
   localparam logic [4:0] OFF_BOOT0   = 5'h10;

   // Configuration register fields
   localparam int CFG_STOP_BIT = 15;
   localparam int CFG_BOOT_BIT = 14;
   localparam int CFG_LOCK_BIT = 12;
   localparam int CFG_ASPC_LSB = 8;
   localparam int CFG_WAIT_LSB = 6;
   localparam int ASPC_PROG_ONLY_BIT = 0;
   localparam int BASE_LO_LSB  = 13;

   // Access size codes on the memory port
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_WORD = 2'h1;
   localparam logic [1:0] SIZE_LONG = 2'h2;

   // Mask-programmed defaults
   localparam logic       DEF_BOOT    = 1'b0;
   localparam logic       DEF_LOCK    = 1'b0;
   localparam logic [1:0] DEF_ASPC    = 2'h0;
   localparam logic [1:0] DEF_WAIT    = 2'h0;
   localparam logic [7:0] DEF_BASE_HI = 8'h00;
   localparam logic [2:0] DEF_BASE_LO = 3'h2;
   localparam logic [15:0] SIG_HI     = 16'h5A3C;
   localparam logic [15:0] SIG_LO     = 16'hC3A5;
   localparam logic [15:0] BOOTSTRAP_WORDS [0:3] = '{16'h0000, 16'h0400, 16'h0000, 16'h4000};
   localparam logic [15:0] ROM_SEED   = 16'h9E37;

   // System clocks per transfer for each wait setting
   localparam logic [CNT_W-1:0] XFER_CLK_W0 = 4'h3;
   localparam logic [CNT_W-1:0] XFER_CLK_W1 = 4'h4;
   localparam logic [CNT_W-1:0] XFER_CLK_W2 = 4'h5;
   localparam logic [CNT_W-1:0] XFER_CLK_W3 = 4'h2;
   localparam logic [CNT_W-1:0] XFER_MIN    = 4'h2;
   localparam logic [CNT_W-1:0] XFER_LOAD_OFS = 4'h3;
   localparam logic [2:0] BOOT_WORD_COUNT = 3'h4;
endpackage

// *** rtl/mrom_sync.sv ***
// Two-flop synchroniser for a level arriving from a pin.
// Assumes the level is slow compared with the system clock.
`timescale 1ns/1ps
module mrom_sync
(
   input  wire logic sys_clk_i,
   input  wire logic srst_i,
   input  wire logic level_i,
   output logic      level_o
);
   logic meta_q;

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         meta_q  <= 1'b0;
         level_o <= 1'b0;
      end
      else
      begin
         meta_q  <= level_i;
         level_o <= meta_q;
      end
   end
endmodule

// *** rtl/mrom_array.sv ***
// Mask-programmed 8 Kbyte read-only array, one combinational read port.
// Assumes contents are fixed at mask time; no write path exists at all.
`timescale 1ns/1ps
module mrom_array
   import mrom_pkg::*;
(
   input  wire logic [mrom_pkg::ROM_IDX_W-1:0] word_idx_i,
   output logic      [15:0]                    word_o
);
   // Contents stand in for the mask pattern; the seed is arbitrary
   always_comb
   begin
      word_o = {word_idx_i[7:0], word_idx_i[11:4]} ^ ROM_SEED;
   end
endmodule

// *** rtl/mrom_unit.sv ***
// Masked read-only array controller: register block, base mapping,
// space filtering, wait-state sequencing, stop and reset bootstrap vectors.
// Assumes one bus master that waits for the acknowledge before a new request.
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module mrom_unit
   import mrom_pkg::*;
(
   input  wire logic                             sys_clk_i,
   input  wire logic                             srst_i,
   input  wire logic [mrom_pkg::REG_OFF_W-1:0]   reg_addr_i,
   input  wire logic [mrom_pkg::REG_DATA_W-1:0]  reg_wdata_i,
   input  wire logic                             reg_wr_i,
   input  wire logic                             reg_rd_i,
   output logic      [mrom_pkg::REG_DATA_W-1:0]  reg_rdata_o,
   input  wire logic                             mem_req_i,
   input  wire logic [mrom_pkg::ADDR_W-1:0]      mem_addr_i,
   input  wire logic [1:0]                       mem_size_i,
   input  wire logic                             mem_prog_i,
   input  wire logic                             mem_wr_i,
   input  wire logic [mrom_pkg::REG_DATA_W-1:0]  mem_wdata_i,
   output logic                                  mem_ack_o,
   output logic      [mrom_pkg::MEM_DATA_W-1:0]  mem_rdata_o,
   input  wire logic                             data_line_fourteen_i,
   output logic                                  stop_o,
   output logic                                  boot_vectors_active_o,
   output logic                                  boot_chip_select_enable_o
);
   import mrom_pkg::*;

   typedef enum logic {ST_IDLE, ST_BUSY} mrom_state_t;
   typedef enum logic [1:0] {KIND_ARR, KIND_REG, KIND_BOOT} mrom_kind_t;

   mrom_state_t      state_q;
   mrom_kind_t       kind_d;
   mrom_kind_t       lat_kind_q;
   mrom_kind_t       sel_kind;
   logic             stop_q;
   logic             lock_q;
   logic [1:0]       aspc_q;
   logic [1:0]       wait_q;
   logic [7:0]       base_hi_q;
   logic [2:0]       base_lo_q;
   logic             boot_active_q;
   logic [2:0]       boot_cnt_q;
   logic [CNT_W-1:0] cnt_q;
   logic [23:0]      lat_addr_q;
   logic [1:0]       lat_size_q;
   logic             lat_two_q;
   logic             lat_wr_q;
   logic             d14_sync;
   logic [15:0]      reg_view [0:15];
   logic             reg_hit;
   logic             arr_hit;
   logic             boot_hit;
   logic             space_ok;
   logic             serve;
   logic             two_d;
   logic [CNT_W-1:0] clk_per;
   logic [CNT_W-1:0] total_d;
   logic             finish;
   logic [23:0]      sel_addr;
   logic [1:0]       sel_size;
   logic             sel_two;
   logic             sel_wr;
   logic [ROM_IDX_W-1:0] rom_idx [0:1];
   logic [15:0]      rom_word [0:1];
   logic [15:0]      w0;
   logic [15:0]      w1;
   logic [31:0]      fmt;
   logic             mem_reg_wr;
   logic             wr_en;
   logic [4:0]       wr_off;
   logic [15:0]      wr_data;
   logic [3:0]       reg_idx1;
   logic [1:0]       boot_idx1;
   logic [2:0]       boot_cnt_d;

   mrom_sync u_d14_sync
   (
      .sys_clk_i (sys_clk_i),
      .srst_i    (1'b0),
      .level_i   (data_line_fourteen_i),
      .level_o   (d14_sync)
   );

   // Register view; every word not listed reads as zero
   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         reg_view[i] = 16'h0000;
      end
      reg_view[OFF_CONFIG[4:1]][CFG_STOP_BIT] = stop_q;
      reg_view[OFF_CONFIG[4:1]][CFG_BOOT_BIT] = boot_chip_select_enable_o;
      reg_view[OFF_CONFIG[4:1]][CFG_LOCK_BIT] = lock_q;
      reg_view[OFF_CONFIG[4:1]][CFG_ASPC_LSB +: 2] = aspc_q;
      reg_view[OFF_CONFIG[4:1]][CFG_WAIT_LSB +: 2] = wait_q;
      reg_view[OFF_BASE_HI[4:1]][7:0] = base_hi_q;
      reg_view[OFF_BASE_LO[4:1]][15:13] = base_lo_q;
      reg_view[OFF_SIG_HI[4:1]] = SIG_HI;
      reg_view[OFF_SIG_LO[4:1]] = SIG_LO;
      for (int i = 0; i < 4; i++)
      begin
         reg_view[OFF_BOOT0[4:1] + 4'(i)] = BOOTSTRAP_WORDS[i];
      end
   end

   // Request decode on the memory port
   always_comb
   begin
      reg_hit  = mem_addr_i[23:REG_BLOCK_LSB] == REG_BLOCK_BASE[23:REG_BLOCK_LSB];
      arr_hit  = mem_addr_i[23:ROM_BLOCK_LSB] == {base_hi_q, base_lo_q};
      space_ok = mem_prog_i | ~aspc_q[ASPC_PROG_ONLY_BIT];
      boot_hit = boot_active_q & mem_prog_i & ~mem_wr_i
                 & (mem_addr_i[23:3] == 21'h000000);
      if (boot_hit)
      begin
         kind_d = KIND_BOOT;
      end
      else if (reg_hit)
      begin
         kind_d = KIND_REG;
      end
      else
      begin
         kind_d = KIND_ARR;
      end
      serve = mem_req_i & (state_q == ST_IDLE)
              & (boot_hit | reg_hit | (arr_hit & ~stop_q & space_ok));
   end

   // Transfer length from the wait field
   always_comb
   begin
      case (wait_q)
         2'h0:    clk_per = XFER_CLK_W0;
         2'h1:    clk_per = XFER_CLK_W1;
         2'h2:    clk_per = XFER_CLK_W2;
         default: clk_per = XFER_CLK_W3;
      endcase
      two_d = (mem_size_i == SIZE_LONG)
              | ((mem_size_i == SIZE_WORD) & mem_addr_i[0]);
      total_d = two_d ? CNT_W'(clk_per << 1) : clk_per;
   end

   // Every transfer passes through the busy state, so the answer is never early
   always_comb
   begin
      if (state_q == ST_IDLE)
      begin
         sel_addr = mem_addr_i;
         sel_size = mem_size_i;
         sel_two  = two_d;
         sel_wr   = mem_wr_i;
         sel_kind = kind_d;
      end
      else
      begin
         sel_addr = lat_addr_q;
         sel_size = lat_size_q;
         sel_two  = lat_two_q;
         sel_wr   = lat_wr_q;
         sel_kind = lat_kind_q;
      end
      finish = (state_q == ST_BUSY) & (cnt_q == '0);
   end

   assign rom_idx[0] = sel_addr[ROM_BLOCK_LSB-1:1];
   assign rom_idx[1] = ROM_IDX_W'(sel_addr[ROM_BLOCK_LSB-1:1] + 12'h001);

   genvar p;
   generate
      for (p = 0; p < 2; p++)
      begin : g_port
         mrom_array u_rom
         (
            .word_idx_i (rom_idx[p]),
            .word_o     (rom_word[p])
         );
      end
   endgenerate

   // Word pair and big-endian lane selection
   always_comb
   begin
      reg_idx1  = 4'(sel_addr[4:1] + 4'h1);
      boot_idx1 = 2'(sel_addr[2:1] + 2'h1);
      case (sel_kind)
         KIND_REG:
         begin
            w0 = reg_view[sel_addr[4:1]];
            w1 = reg_view[reg_idx1];
         end
         KIND_BOOT:
         begin
            w0 = BOOTSTRAP_WORDS[sel_addr[2:1]];
            w1 = BOOTSTRAP_WORDS[boot_idx1];
         end
         default:
         begin
            w0 = rom_word[0];
            w1 = rom_word[1];
         end
      endcase
      if (sel_size == SIZE_LONG)
      begin
         fmt = {w0, w1};
      end
      else if (sel_size == SIZE_WORD)
      begin
         fmt = sel_two ? {16'h0000, w0[7:0], w1[15:8]} : {16'h0000, w0};
      end
      else
      begin
         fmt = {24'h000000, sel_addr[0] ? w0[7:0] : w0[15:8]};
      end
   end

   // Register writes; the plain port wins a same-cycle collision
   always_comb
   begin
      mem_reg_wr = serve & (kind_d == KIND_REG) & mem_wr_i;
      wr_en      = reg_wr_i | mem_reg_wr;
      wr_off     = reg_wr_i ? reg_addr_i : mem_addr_i[4:0];
      wr_data    = reg_wr_i ? reg_wdata_i : mem_wdata_i;
   end

   // Sequencer
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         state_q    <= ST_IDLE;
         cnt_q      <= '0;
         lat_addr_q <= 24'h000000;
         lat_size_q <= SIZE_BYTE;
         lat_two_q  <= 1'b0;
         lat_wr_q   <= 1'b0;
         lat_kind_q <= KIND_ARR;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (serve)
               begin
                  lat_addr_q <= mem_addr_i;
                  lat_size_q <= mem_size_i;
                  lat_two_q  <= two_d;
                  lat_wr_q   <= mem_wr_i;
                  lat_kind_q <= kind_d;
                  cnt_q      <= CNT_W'(total_d - XFER_MIN);
                  state_q    <= ST_BUSY;
               end
            end
            ST_BUSY:
            begin
               if (cnt_q == '0)
               begin
                  state_q <= ST_IDLE;
               end
               else
               begin
                  cnt_q <= CNT_W'(cnt_q - 4'h1);
               end
            end
            default:
            begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Answer; array writes are acknowledged and change nothing
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         mem_ack_o   <= 1'b0;
         mem_rdata_o <= 32'h00000000;
      end
      else
      begin
         mem_ack_o   <= finish;
         mem_rdata_o <= (finish && !sel_wr) ? fmt : 32'h00000000;
      end
   end

   // Plain register port read, data in the following cycle only
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         reg_rdata_o <= 16'h0000;
      end
      else
      begin
         reg_rdata_o <= reg_rd_i ? reg_view[reg_addr_i[4:1]] : 16'h0000;
      end
   end

   // Stop bit; the strap is caught while reset is held
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         stop_q <= ~d14_sync;
      end
      else if (wr_en && wr_off[4:1] == OFF_CONFIG[4:1])
      begin
         stop_q <= wr_data[CFG_STOP_BIT];
      end
   end

   // Lock is one-way, so a stray write can never remap the array
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         lock_q <= DEF_LOCK;
      end
      else if (wr_en && wr_off[4:1] == OFF_CONFIG[4:1] && !lock_q)
      begin
         lock_q <= wr_data[CFG_LOCK_BIT];
      end
   end

   // Space and wait fields are frozen only by a masked lock
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         aspc_q <= DEF_ASPC;
         wait_q <= DEF_WAIT;
      end
      else if (wr_en && wr_off[4:1] == OFF_CONFIG[4:1] && !DEF_LOCK)
      begin
         aspc_q <= wr_data[CFG_ASPC_LSB +: 2];
         wait_q <= wr_data[CFG_WAIT_LSB +: 2];
      end
   end

   // Base registers
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         base_hi_q <= DEF_BASE_HI;
         base_lo_q <= DEF_BASE_LO;
      end
      else if (wr_en && stop_q && !lock_q)
      begin
         if (wr_off[4:1] == OFF_BASE_HI[4:1])
         begin
            base_hi_q <= wr_data[7:0];
         end
         if (wr_off[4:1] == OFF_BASE_LO[4:1])
         begin
            base_lo_q <= wr_data[15:BASE_LO_LSB];
         end
      end
   end

   // Bootstrap vectors retire after four words have been fetched
   always_comb
   begin
      boot_cnt_d = 3'(boot_cnt_q + (sel_two ? 3'h2 : 3'h1));
   end

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         boot_active_q <= ~DEF_BOOT;
         boot_cnt_q    <= 3'h0;
      end
      else if (finish && sel_kind == KIND_BOOT)
      begin
         boot_cnt_q <= boot_cnt_d;
         if (boot_cnt_d >= BOOT_WORD_COUNT)
         begin
            boot_active_q <= 1'b0;
         end
      end
   end

   // Status outputs
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         stop_o                    <= 1'b0;
         boot_vectors_active_o     <= 1'b0;
         boot_chip_select_enable_o <= DEF_BOOT;
      end
      else
      begin
         stop_o                    <= stop_q;
         boot_vectors_active_o     <= boot_active_q;
         boot_chip_select_enable_o <= DEF_BOOT;
      end
   end
endmodule

// *** testbench/mrom_unit_props.sv ***
// Port-level checks for the masked read-only array controller.
// Assumes one system clock and a synchronous active-high reset.
`timescale 1ns/1ps
module mrom_unit_props
   import mrom_pkg::*;
(
   input wire logic        sys_clk_i,
   input wire logic        srst_i,
   input wire logic [4:0]  reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic        mem_req_i,
   input wire logic [23:0] mem_addr_i,
   input wire logic        mem_ack_o,
   input wire logic [31:0] mem_rdata_o,
   input wire logic        stop_o,
   input wire logic        boot_vectors_active_o,
   input wire logic        boot_chip_select_enable_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (srst_i);

   // Longest transfer is a doubled five-clock access
   sequence quiet_span;
      (!mem_ack_o) [*8] ##1 !mem_ack_o ##1 !mem_ack_o;
   endsequence
   sequence stopped_array_req;
      mem_req_i && stop_o && !boot_vectors_active_o
         && mem_addr_i[23:5] != REG_BLOCK_BASE[23:5];
   endsequence

   chk_ack_single: assert property (mem_ack_o |=> !mem_ack_o)
      else $error("acknowledge held longer than one cycle");
   chk_rdata_idle: assert property (!mem_ack_o |-> mem_rdata_o == 32'h0)
      else $error("memory read data present without acknowledge");
   chk_min_two_clk: assert property (mem_req_i |=> !mem_ack_o)
      else $error("transfer shorter than two clocks");
   chk_stop_refuse: assert property (stopped_array_req |-> ##1 quiet_span)
      else $error("array answered while stopped");
   chk_reg_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0)
      else $error("register read data outside read cycle");
   chk_sig_read: assert property (reg_rd_i && reg_addr_i[4:1] == 4'h4 |=> reg_rdata_o == SIG_HI)
      else $error("signature word mismatch");
   chk_unimpl_zero: assert property (reg_rd_i && reg_addr_i[4:1] inside {4'h1, 4'h6, 4'h7, 4'hC,
      4'hD, 4'hE, 4'hF} |=> reg_rdata_o == 16'h0)
      else $error("unimplemented location read nonzero");
   chk_stop_mirror: assert property (reg_wr_i && reg_addr_i[4:1] == 4'h0 |-> ##2
      stop_o == $past(reg_wdata_i[15], 2))
      else $error("stop output does not follow written stop bit");
   chk_boot_select: assert property (!$past(srst_i) && !$past(srst_i, 2) |->
      boot_chip_select_enable_o == DEF_BOOT && !(DEF_BOOT && boot_vectors_active_o))
      else $error("boot source does not match mask default");
endmodule

bind mrom_unit mrom_unit_props u_props (
   .sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .mem_req_i(mem_req_i), .mem_addr_i(mem_addr_i),
   .mem_ack_o(mem_ack_o), .mem_rdata_o(mem_rdata_o), .stop_o(stop_o),
   .boot_vectors_active_o(boot_vectors_active_o),
   .boot_chip_select_enable_o(boot_chip_select_enable_o));

// *** testbench/mrom_bus_master.sv ***
// Bus master model standing in for the processor core on the memory port.
// Assumes the bench calls its access task, one transfer at a time.
`timescale 1ns/1ps
module mrom_bus_master
   import mrom_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        mem_ack_i,
   input  wire logic [31:0] mem_rdata_i,
   output logic             mem_req_o,
   output logic [23:0]      mem_addr_o,
   output logic [1:0]       mem_size_o,
   output logic             mem_prog_o,
   output logic             mem_wr_o,
   output logic [15:0]      mem_wdata_o
);
   initial
   begin
      mem_req_o   = 1'b0;
      mem_addr_o  = 24'hFFFFFF;
      mem_size_o  = 2'h0;
      mem_prog_o  = 1'b0;
      mem_wr_o    = 1'b0;
      mem_wdata_o = 16'h0;
   end

   // One outstanding request; callers keep the array base out of the unreachable window
   task automatic access(input logic [23:0] a, input logic [1:0] sz, input logic pr,
                         input logic wr, output logic [31:0] d, output int lat);
      d   = 32'h0;
      lat = 0;
      @(posedge sys_clk_i);
      mem_req_o   <= 1'b1;
      mem_addr_o  <= a;
      mem_size_o  <= sz;
      mem_prog_o  <= pr;
      mem_wr_o    <= wr;
      mem_wdata_o <= ~a[15:0];
      do
      begin
         @(posedge sys_clk_i);
         mem_req_o <= 1'b0;
         #1;
         lat++;
      end
      while (mem_ack_i !== 1'b1 && lat < 16);
      // A refused request reports latency zero
      if (mem_ack_i === 1'b1)
         d = mem_rdata_i;
      else
         lat = 0;
   endtask
endmodule

// *** testbench/mrom_unit_test.sv ***
// Self-checking bench for the masked read-only array controller.
// Assumes the bus master model drives the memory port.
`timescale 1ns/1ps
module mrom_unit_test;
   import mrom_pkg::*;
   localparam logic PRG = 1'b1;
   localparam logic DAT = 1'b0;
   localparam logic RD  = 1'b0;
   localparam logic WR  = 1'b1;
   localparam logic [23:0] A0 = 24'h004000;
   logic        sys_clk_i;
   logic        srst_i;
   logic [4:0]  reg_addr_i;
   logic [15:0] reg_wdata_i;
   logic        reg_wr_i;
   logic        reg_rd_i;
   logic        d14;
   logic [15:0] reg_rdata_o;
   wire         mreq, mprog, mwr, mack, stop_o;
   wire  [23:0] maddr;
   wire  [1:0]  msize;
   wire  [15:0] mwdata;
   wire  [31:0] mrdata;
   int          n_fail;
   int          total_checks;
   int          wst [4] = '{3, 4, 5, 2};
   logic [15:0] rst_val [16] = '{16'h8000, 16'h0, 16'h0, 16'h4000, SIG_HI, SIG_LO, 16'h0,
      16'h0, 16'h0000, 16'h0400, 16'h0000, 16'h4000, 16'h0, 16'h0, 16'h0, 16'h0};
   logic [15:0] w0, w4, w6, w8;

   mrom_unit dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .mem_req_i(mreq), .mem_addr_i(maddr), .mem_size_i(msize),
      .mem_prog_i(mprog), .mem_wr_i(mwr), .mem_wdata_i(mwdata), .mem_ack_o(mack),
      .mem_rdata_o(mrdata), .data_line_fourteen_i(d14), .stop_o(stop_o),
      .boot_vectors_active_o(), .boot_chip_select_enable_o());
   mrom_bus_master bus (.sys_clk_i(sys_clk_i), .mem_ack_i(mack), .mem_rdata_i(mrdata),
      .mem_req_o(mreq), .mem_addr_o(maddr), .mem_size_o(msize), .mem_prog_o(mprog),
      .mem_wr_o(mwr), .mem_wdata_o(mwdata));

   function automatic logic [15:0] rom(input logic [23:0] a);
      return {a[8:1], a[12:5]} ^ ROM_SEED;
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge sys_clk_i);
      reg_wr_i    <= 1'b0;
   endtask

   task automatic reg_read(input logic [4:0] a, input logic [15:0] e);
      @(posedge sys_clk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge sys_clk_i);
      reg_rd_i   <= 1'b0;
      #1;
      check({16'h0, reg_rdata_o}, {16'h0, e});
   endtask

   // A negative expected latency skips the timing compare
   task automatic mem_chk(input logic [23:0] a, input logic [1:0] sz, input logic pr,
                          input logic wr, input logic [31:0] e, input int el);
      logic [31:0] d;
      int          lat;
      bus.access(a, sz, pr, wr, d, lat);
      check(d, e);
      if (el >= 0)
         check(lat, el);
   endtask

   task automatic conclude();
      $display("checks %0d, failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end

   initial
   begin
      #100000;
      n_fail++;
      $display("watchdog expired");
      conclude();
   end

   initial
   begin
      n_fail = 0;
      total_checks = 0;
      srst_i = 1'b1;
      reg_addr_i = 5'h0;
      reg_wdata_i = 16'h0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      d14 = 1'b0;
      w0 = rom(A0);
      w4 = rom(24'h004004);
      w6 = rom(24'h004006);
      w8 = rom(24'h004008);
      repeat (20) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      for (int i = 0; i < 16; i++)
         reg_read(5'(2 * i), rst_val[i]);
      check({31'h0, stop_o}, 32'h1);
      reg_write(5'h02, 16'hFFFF);
      reg_write(5'h1E, 16'hFFFF);
      reg_read(5'h02, 16'h0);
      reg_read(5'h1E, 16'h0);
      $display("reset and register map test finished");
      mem_chk(24'h0, SIZE_LONG, PRG, RD, 32'h00000400, 6);
      mem_chk(24'h4, SIZE_LONG, PRG, RD, 32'h00004000, 6);
      mem_chk(24'h0, SIZE_WORD, PRG, RD, 32'h0, 0);
      mem_chk(A0, SIZE_WORD, PRG, RD, 32'h0, 0);
      reg_write(5'h00, 16'h0000);
      mem_chk(A0, SIZE_WORD, PRG, RD, {16'h0, w0}, 3);
      $display("bootstrap and stop test finished");
      for (int w = 0; w < 4; w++)
      begin
         reg_write(5'h00, 16'(w << 6));
         reg_read(5'h00, 16'(w << 6));
         mem_chk(24'h004004, SIZE_WORD, PRG, RD, {16'h0, w4}, wst[w]);
         mem_chk(24'h004004, SIZE_LONG, PRG, RD, {w4, w6}, 2 * wst[w]);
         mem_chk(24'h004005, SIZE_WORD, PRG, RD, {16'h0, w4[7:0], w6[15:8]}, 2 * wst[w]);
         mem_chk(24'h004008, SIZE_BYTE, PRG, RD, {24'h0, w8[15:8]}, wst[w]);
         mem_chk(24'h004009, SIZE_BYTE, PRG, RD, {24'h0, w8[7:0]}, wst[w]);
      end
      $display("wait state test finished");
      for (int s = 0; s < 4; s++)
      begin
         reg_write(5'h00, 16'(s << 8));
         mem_chk(A0, SIZE_WORD, DAT, RD, s[0] ? 32'h0 : {16'h0, w0}, s[0] ? 0 : 3);
         mem_chk(A0, SIZE_WORD, PRG, RD, {16'h0, w0}, 3);
      end
      reg_write(5'h00, 16'h0000);
      mem_chk(24'h00400A, SIZE_WORD, PRG, WR, 32'h0, 3);
      mem_chk(24'h00400A, SIZE_WORD, PRG, RD, {16'h0, rom(24'h00400A)}, 3);
      $display("space and write test finished");
      reg_write(5'h04, 16'h00FF);
      reg_read(5'h04, 16'h0000);
      reg_write(5'h00, 16'h8000);
      reg_write(5'h04, 16'h00FF);
      reg_write(5'h06, 16'hE000);
      reg_read(5'h04, 16'h00FF);
      reg_read(5'h06, 16'hE000);
      reg_write(5'h00, 16'h0000);
      mem_chk(24'hFFE000, SIZE_WORD, PRG, RD, {16'h0, w0}, 3);
      mem_chk(24'hFFF828, SIZE_WORD, PRG, RD, {16'h0, SIG_HI}, -1);
      mem_chk(A0, SIZE_WORD, PRG, RD, 32'h0, 0);
      reg_write(5'h00, 16'h9000);
      reg_write(5'h04, 16'h0012);
      reg_write(5'h00, 16'h8000);
      reg_read(5'h00, 16'h9000);
      reg_read(5'h04, 16'h00FF);
      $display("base and lock test finished");
      @(posedge sys_clk_i);
      d14 <= 1'b1;
      srst_i <= 1'b1;
      repeat (20) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      reg_read(5'h00, 16'h0000);
      reg_read(5'h04, 16'h0000);
      reg_read(5'h06, 16'h4000);
      $display("second reset test finished");
      conclude();
   end
endmodule
